// ==== hw/sgss_gain_store.sv ====
// Store of both gain sets with registered read ports
`timescale 1ns/10ps
`include "sgss_regs.svh"
module sgss_gain_store (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire sgss_pkg::sgss_word_t wdata_i,
    // Read ports
    input wire logic [3:0] ra_a_i,
    input wire logic [3:0] ra_b_i,
    input wire logic [3:0] ra_c_i,
    output sgss_pkg::sgss_word_t rd_a_o,
    output sgss_pkg::sgss_word_t rd_b_o,
    output sgss_pkg::sgss_word_t rd_c_o
);
    import sgss_pkg::*;

    // Factory values, same for both sets
    function automatic sgss_mem_t sgss_mem_init();
        sgss_mem_t m;
        m = '0;
        // Read registers a and b start on the first scanned entry of each set; rd_c starts at zero
        m.rd_a = `SGSS_RST_SPEED_GAIN;
        m.rd_b = `SGSS_RST_SPEED_GAIN;
        for (int s = 0; s < 2; s++)
        begin
            m.words[s*8+0] = `SGSS_RST_SPEED_GAIN;
            m.words[s*8+1] = `SGSS_RST_INTEG_TIME;
            m.words[s*8+2] = `SGSS_RST_POS_GAIN;
            m.words[s*8+3] = `SGSS_RST_TRQ_FILT;
            m.words[s*8+4] = `SGSS_RST_MF_GAIN;
            m.words[s*8+5] = `SGSS_RST_MF_COMP;
            m.words[s*8+6] = `SGSS_RST_FRIC_GAIN;
        end
        return m;
    endfunction : sgss_mem_init

    localparam sgss_mem_t MEM_INIT = sgss_mem_init();

    sgss_mem_t q;
    sgss_mem_t d;

    // Write and read
    always_comb
    begin
        d = q;
        if (we_i)
        begin
            d.words[waddr_i] = wdata_i;
        end
        d.rd_a = q.words[ra_a_i];
        d.rd_b = q.words[ra_b_i];
        d.rd_c = q.words[ra_c_i];
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            q <= MEM_INIT;
        else
            q <= d;
    end

    assign rd_a_o = q.rd_a;
    assign rd_b_o = q.rd_b;
    assign rd_c_o = q.rd_c;
endmodule : sgss_gain_store

// ==== hw/sgss_pkg.sv ====
// Types of the gain set switcher
package sgss_pkg;
    typedef logic [15:0] sgss_word_t;
    typedef enum logic [1:0] {SGSS_IDLE, SGSS_WAIT, SGSS_RAMP} sgss_fsm_t;

    // Gain store state
    typedef struct packed {
        logic [15:0][15:0] words;
        sgss_word_t rd_a;
        sgss_word_t rd_b;
        sgss_word_t rd_c;
    } sgss_mem_t;

    // Switcher state
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic acc;
        logic [31:0] prdata;
        sgss_word_t cfg;
        sgss_word_t spdcfg;
        sgss_word_t wait1;
        sgss_word_t wait2;
        sgss_word_t ramp1;
        sgss_word_t ramp2;
        sgss_fsm_t fsm;
        logic cur;
        logic goal;
        logic mf;
        logic [16:0] ms_pre;
        logic [15:0] ms_cnt;
        logic [2:0] idx;
        logic [2:0] idx_p;
        logic [6:0][15:0] gain;
    } sgss_state_t;
endpackage : sgss_pkg

// ==== hw/sgss_regs.svh ====
// Register offsets, field positions, reset values and timing of the gain set switcher
//
// What this block does
// - Lowest config digit: 0 manual (default), 2 automatic; applies at once.
// - Each set holds seven gains; set two uses its own copies.
// - Model-following gain and compensation switch only under manual mode.
// - Manual model-following swap only with no motion and motor stopped.
// - Otherwise the five other gains switch; model-following values stay.
// - Manual mode: the gain select command picks set one or two.
// - Auto: condition A true goes to set two, false back to one.
// - Second digit 0..3: positioning_complete_flag on, positioning_complete_flag off, near on, near off.
// - Code 4: filter idle and pulse off; code 5: pulse input on.
// - Outside position control codes 0,2,4 hold set one; 1,3,5 set two.
// - After condition A changes, wait the waiting time before changing.
// - Ramp each gain linearly old to new over exactly the switching time.
// - Automatic switching only with PI or IP speed loop control.
// - Wait and ramp times 0..65535 ms, default 0, apply at once.
// - Tuning-less function active forces gain set one.
`ifndef SGSS_REGS_SVH
`define SGSS_REGS_SVH

// ==========================================================
// Register byte offsets
`define SGSS_CFG_OFS 8'h00
`define SGSS_SPDCFG_OFS 8'h04
`define SGSS_WAIT1_OFS 8'h08
`define SGSS_WAIT2_OFS 8'h0C
`define SGSS_RAMP1_OFS 8'h10
`define SGSS_RAMP2_OFS 8'h14
`define SGSS_STATUS_OFS 8'h18
`define SGSS_GAIN_BASE 2'h1

// ==========================================================
// Fields and codes
`define SGSS_MODE_MANUAL 4'h0
`define SGSS_MODE_AUTO 4'h2
`define SGSS_SPD_PI 4'h0
`define SGSS_SPD_IP 4'h1
`define SGSS_IDX_MF_GAIN 3'h4
`define SGSS_IDX_MF_COMP 3'h5
`define SGSS_IDX_LAST 3'h6

// ==========================================================
// Pin vector positions
`define SGSS_IN_SEL 0
`define SGSS_IN_POSITIONING_COMPLETE_FLAG 1
`define SGSS_IN_NEAR 2
`define SGSS_IN_FILT 3
`define SGSS_IN_PULSE 4
`define SGSS_IN_POS 5
`define SGSS_IN_MOTION 6
`define SGSS_IN_STOP 7
`define SGSS_IN_TL 8

// ==========================================================
// Reset values of the gains
`define SGSS_RST_SPEED_GAIN 16'h0190
`define SGSS_RST_INTEG_TIME 16'h07D0
`define SGSS_RST_POS_GAIN 16'h0190
`define SGSS_RST_TRQ_FILT 16'h0064
`define SGSS_RST_MF_GAIN 16'h01F4
`define SGSS_RST_MF_COMP 16'h03E8
`define SGSS_RST_FRIC_GAIN 16'h0064

// ==========================================================
// Timing: one millisecond unit
`define SGSS_MS_NS 1000000
`define SGSS_CLK_NS 8
`define SGSS_MS_CYCLES ((`SGSS_MS_NS + `SGSS_CLK_NS - 1) / `SGSS_CLK_NS)

`endif

// ==== hw/sgss_top.sv ====
// Gain set switcher: APB registers, manual and automatic set selection, ramping
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "sgss_regs.svh"
module sgss_top #(
    parameter int unsigned MS_CYCLES = `SGSS_MS_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Drive status pins
    input wire logic gain_select_command_i,
    input wire logic positioning_complete_flag_i,
    input wire logic near_position_i,
    input wire logic ref_filter_idle_i,
    input wire logic ref_pulse_on_i,
    input wire logic position_control_i,
    input wire logic motion_executing_i,
    input wire logic motor_stopped_i,
    input wire logic tuningless_active_i,
    // Active gains
    output sgss_pkg::sgss_word_t speed_loop_gain_o,
    output sgss_pkg::sgss_word_t speed_integral_time_o,
    output sgss_pkg::sgss_word_t position_loop_gain_o,
    output sgss_pkg::sgss_word_t torque_filter_time_o,
    output sgss_pkg::sgss_word_t model_follow_gain_o,
    output sgss_pkg::sgss_word_t model_follow_comp_o,
    output sgss_pkg::sgss_word_t friction_comp_gain_o,
    // Switcher status
    output logic active_set_o,
    output logic ramping_o
);
    import sgss_pkg::*;

    // ==========================================================
    // Helpers

    // Mapped address check
    function automatic logic sgss_mapped(input logic [7:0] a);
        if (a[1:0] != 2'h0)
            return 1'b0;
        if (a[7:6] == `SGSS_GAIN_BASE)
            return a[4:2] != 3'h7;
        return a <= `SGSS_STATUS_OFS;
    endfunction : sgss_mapped

    // Linear point between a and b at k of t
    function automatic sgss_word_t sgss_lerp(input sgss_word_t a, input sgss_word_t b,
                                             input logic [15:0] k, input logic [15:0] t);
        logic signed [16:0] diff;
        logic signed [33:0] prod;
        logic signed [33:0] res;
        // Zero time would divide by zero: jump to the new value
        if (t == 16'h0000)
            return b;
        diff = $signed({1'b0, b}) - $signed({1'b0, a});
        prod = 34'(diff * $signed({1'b0, k}));
        res = $signed({18'h0_0000, a}) + prod / $signed({18'h0_0000, t});
        return res[15:0];
    endfunction : sgss_lerp

    sgss_state_t q;
    sgss_state_t d;
    sgss_word_t rd_a;
    sgss_word_t rd_b;
    sgss_word_t rd_c;
    logic mem_we;
    logic wr_go;
    logic ms_tick;
    logic auto_mode;
    logic pi_ip;
    logic cond_a;
    logic want2;
    logic [3:0] ccode;
    sgss_word_t wait_t;
    sgss_word_t ramp_t;
    sgss_word_t va;
    sgss_word_t vb;
    sgss_word_t val;

    // ==========================================================
    // Gain store
    sgss_gain_store u_store (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .we_i(mem_we),
        .waddr_i(paddr_i[5:2]),
        .wdata_i(pwdata_i[15:0]),
        .ra_a_i({1'b0, q.idx}),
        .ra_b_i({1'b1, q.idx}),
        .ra_c_i(paddr_i[5:2]),
        .rd_a_o(rd_a),
        .rd_b_o(rd_b),
        .rd_c_o(rd_c)
    );

    // ==========================================================
    // Bus handshake
    assign pready_o = psel_i & penable_i & q.acc;
    assign pslverr_o = pready_o & ~sgss_mapped(paddr_i);
    assign prdata_o = q.prdata;
    assign wr_go = pready_o & pwrite_i & sgss_mapped(paddr_i);
    assign mem_we = wr_go & (paddr_i[7:6] == `SGSS_GAIN_BASE);

    // ==========================================================
    // Switching condition
    assign auto_mode = q.cfg[3:0] == `SGSS_MODE_AUTO;
    assign pi_ip = (q.spdcfg[3:0] == `SGSS_SPD_PI) | (q.spdcfg[3:0] == `SGSS_SPD_IP);
    assign ccode = q.cfg[7:4];
    assign ms_tick = q.ms_pre == 17'(MS_CYCLES - 1);
    assign wait_t = q.goal ? q.wait1 : q.wait2;
    assign ramp_t = q.goal ? q.ramp1 : q.ramp2;

    // Condition A from the selected source
    always_comb
    begin
        case (ccode)
            4'h0: cond_a = q.sync2[`SGSS_IN_POSITIONING_COMPLETE_FLAG];
            4'h1: cond_a = ~q.sync2[`SGSS_IN_POSITIONING_COMPLETE_FLAG];
            4'h2: cond_a = q.sync2[`SGSS_IN_NEAR];
            4'h3: cond_a = ~q.sync2[`SGSS_IN_NEAR];
            4'h4: cond_a = q.sync2[`SGSS_IN_FILT] & ~q.sync2[`SGSS_IN_PULSE];
            4'h5: cond_a = q.sync2[`SGSS_IN_PULSE];
            default: cond_a = 1'b0;
        endcase
        // Fixed set outside position control
        if (!q.sync2[`SGSS_IN_POS])
            want2 = ccode[0];
        else
            want2 = cond_a;
        if (!pi_ip)
            want2 = 1'b0;
    end

    // Value for the gain whose store data just arrived
    always_comb
    begin
        va = rd_a;
        vb = rd_b;
        if (q.idx_p == `SGSS_IDX_MF_GAIN || q.idx_p == `SGSS_IDX_MF_COMP)
            val = q.mf ? vb : va;
        else if (q.fsm == SGSS_RAMP)
            val = sgss_lerp(q.cur ? vb : va, q.goal ? vb : va, q.ms_cnt, ramp_t);
        else
            val = q.cur ? vb : va;
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        // Pin synchronisers
        d.sync1 = {tuningless_active_i, motor_stopped_i, motion_executing_i,
                   position_control_i, ref_pulse_on_i, ref_filter_idle_i,
                   near_position_i, positioning_complete_flag_i, gain_select_command_i};
        d.sync2 = q.sync1;
        // Bus phase and read data
        d.acc = psel_i & penable_i & ~q.acc;
        if (psel_i && !pready_o)
        begin
            d.prdata = 32'h0000_0000;
            if (paddr_i[7:6] == `SGSS_GAIN_BASE && sgss_mapped(paddr_i))
                d.prdata[15:0] = rd_c;
            else
            begin
                case (paddr_i)
                    `SGSS_CFG_OFS: d.prdata[15:0] = q.cfg;
                    `SGSS_SPDCFG_OFS: d.prdata[15:0] = q.spdcfg;
                    `SGSS_WAIT1_OFS: d.prdata[15:0] = q.wait1;
                    `SGSS_WAIT2_OFS: d.prdata[15:0] = q.wait2;
                    `SGSS_RAMP1_OFS: d.prdata[15:0] = q.ramp1;
                    `SGSS_RAMP2_OFS: d.prdata[15:0] = q.ramp2;
                    `SGSS_STATUS_OFS: d.prdata[3:0] = {q.fsm == SGSS_RAMP,
                                                       q.fsm == SGSS_WAIT, q.mf, q.cur};
                    default: d.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Register writes, effective at once
        if (wr_go)
        begin
            case (paddr_i)
                `SGSS_CFG_OFS: d.cfg = pwdata_i[15:0];
                `SGSS_SPDCFG_OFS: d.spdcfg = pwdata_i[15:0];
                `SGSS_WAIT1_OFS: d.wait1 = pwdata_i[15:0];
                `SGSS_WAIT2_OFS: d.wait2 = pwdata_i[15:0];
                `SGSS_RAMP1_OFS: d.ramp1 = pwdata_i[15:0];
                `SGSS_RAMP2_OFS: d.ramp2 = pwdata_i[15:0];
                default: d.cfg = q.cfg;
            endcase
        end
        // Millisecond timer
        d.ms_pre = ms_tick ? 17'h0_0000 : q.ms_pre + 17'h0_0001;
        if (ms_tick)
            d.ms_cnt = q.ms_cnt + 16'h0001;
        // Set selection
        if (q.sync2[`SGSS_IN_TL])
        begin
            d.cur = 1'b0;
            d.goal = 1'b0;
            d.mf = 1'b0;
            d.fsm = SGSS_IDLE;
        end
        else if (!auto_mode)
        begin
            d.fsm = SGSS_IDLE;
            d.cur = q.sync2[`SGSS_IN_SEL];
            d.goal = q.sync2[`SGSS_IN_SEL];
            if (!q.sync2[`SGSS_IN_MOTION] && q.sync2[`SGSS_IN_STOP])
                d.mf = q.sync2[`SGSS_IN_SEL];
            // Otherwise model-following values stay put
        end
        else
        begin
            d.mf = 1'b0;
            case (q.fsm)
                SGSS_IDLE:
                begin
                    if (want2 != q.cur)
                    begin
                        d.goal = want2;
                        d.fsm = SGSS_WAIT;
                        d.ms_pre = 17'h0_0000;
                        d.ms_cnt = 16'h0000;
                    end
                end
                SGSS_WAIT:
                begin
                    if (want2 == q.cur)
                        d.fsm = SGSS_IDLE;
                    else if (q.ms_cnt >= wait_t)
                    begin
                        d.ms_pre = 17'h0_0000;
                        d.ms_cnt = 16'h0000;
                        if (ramp_t == 16'h0000)
                        begin
                            d.cur = q.goal;
                            d.fsm = SGSS_IDLE;
                        end
                        else
                            d.fsm = SGSS_RAMP;
                    end
                end
                SGSS_RAMP:
                begin
                    if (q.ms_cnt >= ramp_t)
                    begin
                        d.cur = q.goal;
                        d.fsm = SGSS_IDLE;
                    end
                end
                default: d.fsm = SGSS_IDLE;
            endcase
        end
        // Gain scan over the seven entries
        d.idx = (q.idx == `SGSS_IDX_LAST) ? 3'h0 : q.idx + 3'h1;
        d.idx_p = q.idx;
        if (q.idx_p <= `SGSS_IDX_LAST)
            d.gain[q.idx_p] = val;
    end

    // State register, set one idle after reset
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.gain <= {`SGSS_RST_FRIC_GAIN, `SGSS_RST_MF_COMP, `SGSS_RST_MF_GAIN,
                       `SGSS_RST_TRQ_FILT, `SGSS_RST_POS_GAIN, `SGSS_RST_INTEG_TIME,
                       `SGSS_RST_SPEED_GAIN};
        end
        else
            q <= d;
    end

    // ==========================================================
    // Outputs
    assign speed_loop_gain_o = q.gain[0];
    assign speed_integral_time_o = q.gain[1];
    assign position_loop_gain_o = q.gain[2];
    assign torque_filter_time_o = q.gain[3];
    assign model_follow_gain_o = q.gain[4];
    assign model_follow_comp_o = q.gain[5];
    assign friction_comp_gain_o = q.gain[6];
    assign active_set_o = q.cur;
    assign ramping_o = q.fsm == SGSS_RAMP;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    manual_no_timing_a: assert property (!auto_mode |=> q.fsm == SGSS_IDLE)
        else $error("timing active in manual mode");
    auto_mf_one_a: assert property (auto_mode && !q.sync2[`SGSS_IN_TL] |=> !q.mf)
        else $error("model-following set two under automatic mode");
    mf_hold_moving_a: assert property (!auto_mode && !q.sync2[`SGSS_IN_TL] &&
        q.sync2[`SGSS_IN_MOTION] |=> $stable(q.mf))
        else $error("model-following swapped while moving");
    manual_follow_a: assert property (!auto_mode && !q.sync2[`SGSS_IN_TL] |=>
        q.cur == $past(q.sync2[`SGSS_IN_SEL]))
        else $error("manual set not following command");
    wait_holds_set_a: assert property (auto_mode && !q.sync2[`SGSS_IN_TL] &&
        q.fsm == SGSS_WAIT && q.ms_cnt < wait_t |=> $stable(q.cur))
        else $error("set changed while waiting");
    ramp_bound_a: assert property (q.fsm == SGSS_RAMP |-> q.ms_cnt <= ramp_t)
        else $error("ramp ran past its time");
    wait1_write_a: assert property (wr_go && paddr_i == `SGSS_WAIT1_OFS |=>
        q.wait1 == $past(pwdata_i[15:0]))
        else $error("waiting time one not written");
    tuningless_one_a: assert property (q.sync2[`SGSS_IN_TL] |=>
        !q.cur && q.fsm == SGSS_IDLE)
        else $error("tuning-less not on set one");
    no_pi_one_a: assert property (auto_mode && !pi_ip && !q.sync2[`SGSS_IN_TL] &&
        q.fsm == SGSS_IDLE && !q.cur |=> q.fsm == SGSS_IDLE)
        else $error("switching without PI or IP control");
    cond_start_a: assert property (auto_mode && pi_ip && !q.sync2[`SGSS_IN_TL] &&
        q.fsm == SGSS_IDLE && want2 != q.cur |=> q.fsm == SGSS_WAIT && q.goal != q.cur)
        else $error("condition change did not start waiting");

    // Ramp only after a wait, and ends on the new set
    idle_no_ramp_a: assert property (q.fsm == SGSS_IDLE |=> q.fsm != SGSS_RAMP)
        else $error("ramp started without waiting");
    ramp_end_set_a: assert property (auto_mode && !q.sync2[`SGSS_IN_TL] &&
        q.fsm == SGSS_RAMP && q.ms_cnt >= ramp_t |=>
        q.fsm == SGSS_IDLE && q.cur == $past(q.goal))
        else $error("ramp did not end on the new set");

    // Fixed set and tuning-less model-following
    fixed_set_hold_a: assert property (auto_mode && pi_ip && !q.sync2[`SGSS_IN_TL] &&
        !q.sync2[`SGSS_IN_POS] && q.fsm == SGSS_IDLE && q.cur == ccode[0] |=>
        q.fsm == SGSS_IDLE)
        else $error("fixed set left outside position control");
    tuningless_mf_a: assert property (q.sync2[`SGSS_IN_TL] |=> !q.mf)
        else $error("tuning-less not on model-following set one");
endmodule : sgss_top

// ==== test/sgss_cmd_model.sv ====
// Command option module model that drives the gain select command
`timescale 1ns/10ps
module sgss_cmd_model (
    // Clock
    input wire logic sys_clk_i,
    // Request and answer delay from the bench
    input wire logic want_set_two_i,
    input wire logic [3:0] delay_i,
    // Command to the switcher
    output logic gain_select_command_o
);
    logic [3:0] cnt_q = 4'h0;
    logic cmd_q = 1'b0;

    // Follows the request promptly or after some cycles
    always @(posedge sys_clk_i)
    begin
        if (want_set_two_i == cmd_q)
            cnt_q <= 4'h0;
        else if (cnt_q >= delay_i)
            cmd_q <= want_set_two_i;
        else
            cnt_q <= cnt_q + 4'h1;
    end
    assign gain_select_command_o = cmd_q;
endmodule : sgss_cmd_model

// ==== test/tb_servo_gain_set_switcher.sv ====
// Self-checking testbench of the gain set switcher
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_servo_gain_set_switcher;
    import sgss_pkg::*;
    // ==========================================================
    // Signals
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic pready, pslverr, act, ramping, cmd, err, hit;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic positioning_complete_flag = 1'b0, near = 1'b0, filt = 1'b0, pulse = 1'b0, posctl = 1'b0;
    logic motion = 1'b0, stopped = 1'b0, tl = 1'b0, want = 1'b0;
    logic [3:0] dly = 4'h0;
    sgss_word_t g [7];
    sgss_word_t a_tab [7] = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h01F4,
        16'h03E8, 16'h0064};
    sgss_word_t b_tab [7] = '{16'h0300, 16'h0900, 16'h0800, 16'h0200, 16'h0400,
        16'h0500, 16'h0050};
    logic [3:0] t_tab [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
    logic [3:0] f_tab [6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h0, 4'h0};
    int bad_count = 0, tests_run = 0, cyc = 0, n, m;

    // ==========================================================
    // Design and command option model
    sgss_top #(.MS_CYCLES(4)) u_sgss_top (
        .sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .gain_select_command_i(cmd),
        .positioning_complete_flag_i(positioning_complete_flag), .near_position_i(near),
        .ref_filter_idle_i(filt), .ref_pulse_on_i(pulse),
        .position_control_i(posctl), .motion_executing_i(motion),
        .motor_stopped_i(stopped), .tuningless_active_i(tl),
        .speed_loop_gain_o(g[0]), .speed_integral_time_o(g[1]),
        .position_loop_gain_o(g[2]), .torque_filter_time_o(g[3]),
        .model_follow_gain_o(g[4]), .model_follow_comp_o(g[5]),
        .friction_comp_gain_o(g[6]), .active_set_o(act), .ramping_o(ramping)
    );
    sgss_cmd_model u_sgss_cmd_model (
        .sys_clk_i(clk), .want_set_two_i(want), .delay_i(dly),
        .gain_select_command_o(cmd)
    );

    // Clock and hang guard
    initial forever #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Tasks
    task report_and_stop;
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // One APB transfer, held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0000_0000);
        `CHK(rd, e);
    endtask : rchk

    task automatic chk_gains(input logic two, input logic mf);
        for (int i = 0; i < 7; i++)
            `CHK(g[i], (((i == 4 || i == 5) ? mf : two) ? b_tab[i] : a_tab[i]));
    endtask : chk_gains

    // Waits, then stops at a falling edge where outputs are settled
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle(12);
        chk_gains(1'b0, 1'b0);
        `CHK(act, 1'b0);
        for (int i = 0; i < 7; i++)
            rchk(8'h40 + 8'(4 * i), {16'h0000, a_tab[i]});
        for (int i = 0; i < 6; i++)
            rchk(8'(4 * i), 32'h0000_0000);
        rchk(8'h5C, 32'h0000_0000);
        `CHK(err, 1'b1);
        for (int i = 0; i < 7; i++)
            apb(1'b1, 8'h60 + 8'(4 * i), {16'h0000, b_tab[i]});
        rchk(8'h78, {16'h0000, b_tab[6]});
        // Manual selection with the motor at rest
        stopped <= 1'b1;
        want <= 1'b1;
        settle(24);
        chk_gains(1'b1, 1'b1);
        `CHK(act, 1'b1);
        // Slow command while a motion runs
        @(posedge clk);
        motion <= 1'b1;
        want <= 1'b0;
        dly <= 4'h9;
        settle(36);
        chk_gains(1'b0, 1'b1);
        @(posedge clk);
        motion <= 1'b0;
        settle(16);
        chk_gains(1'b0, 1'b0);
        // Automatic switch with wait and ramp, entered from manual set two
        @(posedge clk);
        want <= 1'b1;
        apb(1'b1, 8'h08, 32'h0000_0002);
        apb(1'b1, 8'h10, 32'h0000_0004);
        apb(1'b1, 8'h14, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0002);
        want <= 1'b0;
        posctl <= 1'b1;
        settle(12);
        @(posedge clk);
        positioning_complete_flag <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ramping !== 1'b1);
        `CHK(n >= 10, 1'b1);
        m = 0;
        hit = 1'b0;
        while (ramping === 1'b1)
        begin
            if (g[2] > a_tab[2] && g[2] < b_tab[2])
                hit = 1'b1;
            m++;
            @(negedge clk);
        end
        `CHK(m >= 16 && m <= 17, 1'b1);
        `CHK(hit, 1'b1);
        settle(12);
        chk_gains(1'b1, 1'b0);
        `CHK(act, 1'b1);
        @(posedge clk);
        positioning_complete_flag <= 1'b0;
        settle(30);
        chk_gains(1'b0, 1'b0);
        // Condition gone again before the wait ran out
        apb(1'b1, 8'h08, 32'h0000_0006);
        positioning_complete_flag <= 1'b1;
        settle(12);
        rchk(8'h18, 32'h0000_0004);
        @(posedge clk);
        positioning_complete_flag <= 1'b0;
        hit = 1'b0;
        repeat (60)
        begin
            @(negedge clk);
            if (ramping === 1'b1)
                hit = 1'b1;
        end
        `CHK(hit, 1'b0);
        `CHK(act, 1'b0);
        // Every condition code, in and out of position control
        apb(1'b1, 8'h08, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'h0000_0000);
        apb(1'b1, 8'h14, 32'h0000_0000);
        for (int c = 0; c < 6; c++)
        begin
            apb(1'b1, 8'h00, {24'h00_0002, 4'(c), 4'h2});
            posctl <= 1'b1;
            {positioning_complete_flag, near, filt, pulse} <= t_tab[c];
            settle(30);
            `CHK(act, 1'b1);
            @(posedge clk);
            {positioning_complete_flag, near, filt, pulse} <= f_tab[c];
            settle(30);
            `CHK(act, 1'b0);
            @(posedge clk);
            posctl <= 1'b0;
            settle(30);
            `CHK(act, c[0]);
        end
        // Speed loop kind, tuning-less and return to manual
        apb(1'b1, 8'h00, 32'h0000_0002);
        posctl <= 1'b1;
        apb(1'b1, 8'h04, 32'h0000_0002);
        positioning_complete_flag <= 1'b1;
        settle(30);
        `CHK(act, 1'b0);
        apb(1'b1, 8'h04, 32'h0000_0001);
        settle(30);
        `CHK(act, 1'b1);
        @(posedge clk);
        tl <= 1'b1;
        settle(12);
        chk_gains(1'b0, 1'b0);
        @(posedge clk);
        tl <= 1'b0;
        settle(30);
        `CHK(act, 1'b1);
        apb(1'b1, 8'h00, 32'h0000_0000);
        settle(20);
        `CHK(act, 1'b0);
        report_and_stop();
    end
endmodule : tb_servo_gain_set_switcher
